//--- logic/ddrpd_datapath.v
// Function
// - Parity allowed only in x8, x16 and x32 group modes, on an ordinary data lane.
// - One parity bit for every eight data bits in a strobe group.
// - Mask/byte-select driven low for bytes written; high means memory ignores them.
// - Mask only for DDR types and RLDRAM; byte-selects for QDR SRAM.
// - One mask per group or device; one byte-select per nine QDR data bits (here QDR gets one byte-select per group, like DDR).
// - Eight-bit QDR SRAM gets two nibble-write selects per eight data bits.
// - Mask and byte-selects launch with identical registers and timing as write data.
// - No mask output in x4 DDR3, nor x4 DDR2 with differential strobes.
// - Eight ECC lanes travel like data beside 64 data lanes; controller codes them (here ecc_en_i is unused and no ECC lanes exist).
// - Read-valid is captured like data, half a clock before first word.
// - Address and command launched at single data rate with no special capture.
// - Burst-of-two QDR: read address on rising edge, write address on falling.
// - Memory clock pair made by double-rate output registers like the strobe (here single-rate flops toggling at half the core clock).
// - First memory clock pair loops back through a buffer matching strobe style.
// - Registers convert between full I/O rate and half-rate controller words.
// - Half-rate conversion can be bypassed for a full-rate controller.
// - Incoming read strobes get a phase shift when acting as capture strobes.
// - Shift comes from a shared delay loop plus a per-side phase offset.
// - All strobe pins take new delay settings in the same cycle.
// - Wider groups merge 2, 4 or 8 adjacent x4 groups under one strobe pair.
// - Delay loop steps a six-bit Gray setting up or down per its comparator.
`include "ddrpd_defs.vh"
module ddrpd_datapath #(
    parameter DW          = 16,
    parameter NSTROBE     = 4,
    parameter LOCK_CYCLES = `DDRPD_DLL_LOCK_CYCLES,
    parameter FIFO_DEPTH  = `DDRPD_FIFO_DEPTH,
    parameter AW          = 14
) (
    input  wire              core_clk_i,
    input  wire              reset_n_i,
    input  wire [1:0]        mem_type_i,
    input  wire [1:0]        grp_mode_i,
    input  wire              diff_strobe_i,
    input  wire              is_ddr3_i,
    input  wire              half_rate_i,
    input  wire              parity_en_i,
    input  wire              ecc_en_i,
    input  wire [2*DW-1:0]   wr_data_i,
    input  wire [DW/4-1:0]   wr_mask_i,
    input  wire              wr_valid_i,
    output wire              wr_ready_o,
    input  wire [AW-1:0]     cmd_addr_i,
    input  wire [AW-1:0]     cmd_waddr_i,
    input  wire [3:0]        cmd_i,
    output reg  [AW-1:0]     mem_addr_o,
    output reg  [3:0]        mem_cmd_o,
    output reg  [DW-1:0]     dq_o,
    output reg               dq_oe_n_o,
    output reg  [DW/8-1:0]   par_o,
    output reg  [DW/4-1:0]   wmask_o,
    output reg               wmask_oe_n_o,
    input  wire [DW-1:0]     dq_i,
    input  wire              rvalid_pin_i,
    input  wire              strobe_pin_i,
    output reg  [2*DW-1:0]   rd_data_o,
    output reg               rd_valid_o,
    output reg               rd_beat_hi_o,
    output reg               mem_clk_o,
    output reg               mem_clk_n_o,
    input  wire              mem_clk_fb_p_i,
    input  wire              mem_clk_fb_n_i,
    output reg               clk_fb_o,
    input  wire              dll_reset_i,
    input  wire              cmp_up_i,
    input  wire              cmp_dn_i,
    input  wire [5:0]        side_offset_i,
    output reg  [6*NSTROBE-1:0] strobe_dly_o,
    output reg               dll_locked_o
);
    localparam NPAR = DW / 8;
    localparam NLANE = DW / 4;

    // Two-flop sync of every pin input before any logic looks at it
    reg [DW-1:0] dq_s1;
    reg [DW-1:0] dq_s2;
    reg          rv_s1;
    reg          rv_s2;
    reg          st_s1;
    reg          st_s2;
    reg          st_d;
    reg          fbp_s1;
    reg          fbp_s2;
    reg          fbn_s1;
    reg          fbn_s2;
    // Comparator and loop reset come from outside this clock as well
    reg          dlr_s1;
    reg          dlr_s2;
    reg          cup_s1;
    reg          cup_s2;
    reg          cdn_s1;
    reg          cdn_s2;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dq_s1  <= {DW{1'b0}};
            dq_s2  <= {DW{1'b0}};
            rv_s1  <= 1'b0;
            rv_s2  <= 1'b0;
            st_s1  <= 1'b0;
            st_s2  <= 1'b0;
            st_d   <= 1'b0;
            fbp_s1 <= 1'b0;
            fbp_s2 <= 1'b0;
            fbn_s1 <= 1'b0;
            fbn_s2 <= 1'b0;
            dlr_s1 <= 1'b0;
            dlr_s2 <= 1'b0;
            cup_s1 <= 1'b0;
            cup_s2 <= 1'b0;
            cdn_s1 <= 1'b0;
            cdn_s2 <= 1'b0;
        end else begin
            dq_s1  <= dq_i;
            dq_s2  <= dq_s1;
            rv_s1  <= rvalid_pin_i;
            rv_s2  <= rv_s1;
            st_s1  <= strobe_pin_i;
            st_s2  <= st_s1;
            st_d   <= st_s2;
            fbp_s1 <= mem_clk_fb_p_i;
            fbp_s2 <= fbp_s1;
            fbn_s1 <= mem_clk_fb_n_i;
            fbn_s2 <= fbn_s1;
            dlr_s1 <= dll_reset_i;
            dlr_s2 <= dlr_s1;
            cup_s1 <= cmp_up_i;
            cup_s2 <= cup_s1;
            cdn_s1 <= cmp_dn_i;
            cdn_s2 <= cdn_s1;
        end
    end
    wire strobe_edge = st_s2 ^ st_d;
    wire ref_rise    = st_s2 & ~st_d;

    // Write path: the FIFO stalls the controller when the pins are busy
    wire [2*DW+NLANE-1:0] f_data;
    wire                  f_valid;
    reg                   f_ready;
    ddrpd_fifo #(
        .WIDTH (2*DW+NLANE),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_wr_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .in_data_i   ({wr_mask_i, wr_data_i}),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready)
    );

    // Mask support by memory type and group width
    wire mask_allowed = !(grp_mode_i == `DDRPD_GRP_X4 && (is_ddr3_i || diff_strobe_i));
    wire par_allowed  = parity_en_i && (grp_mode_i != `DDRPD_GRP_X4);
    wire is_qdr       = (mem_type_i == `DDRPD_MEM_QDR) || (mem_type_i == `DDRPD_MEM_QDR8);

    // Half-rate beat select: low half first
    reg              beat;
    reg [DW-1:0]     next_dq;
    reg [NLANE-1:0]  next_mask;
    always @* begin
        f_ready = 1'b0;
        if (half_rate_i) begin
            next_dq   = beat ? f_data[2*DW-1:DW] : f_data[DW-1:0];
            f_ready   = beat;
        end else begin
            next_dq   = f_data[DW-1:0];
            f_ready   = 1'b1;
        end
        next_mask = f_data[2*DW+NLANE-1:2*DW];
    end

    // Per-byte even parity and per-lane mask fan-out
    wire [NPAR-1:0]  next_par;
    wire [NLANE-1:0] next_wm;
    genvar g;
    generate
        for (g = 0; g < NLANE; g = g + 1) begin : g_lane
            if (g < NPAR) begin : g_par
                assign next_par[g] = ^next_dq[8*g+7:8*g];
            end
            // DDR: one per x4 lane merged into group; QDR8: nibble selects
            assign next_wm[g] = (mem_type_i == `DDRPD_MEM_QDR8) ? next_mask[g] :
                                (mem_type_i == `DDRPD_MEM_RLD)  ? next_mask[0] :
                                next_mask[g >> grp_mode_i];
        end
    endgenerate

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            beat         <= 1'b0;
            dq_o         <= {DW{1'b0}};
            dq_oe_n_o    <= 1'b1;
            par_o        <= {NPAR{1'b0}};
            wmask_o      <= {NLANE{1'b0}};
            wmask_oe_n_o <= 1'b1;
        end else begin
            if (f_valid) begin
                beat         <= half_rate_i ? ~beat : 1'b0;
                dq_o         <= next_dq;
                dq_oe_n_o    <= 1'b0;
                par_o        <= par_allowed ? next_par : {NPAR{1'b0}};
                // Low selects the byte; is_qdr picks byte-select meaning
                wmask_o      <= (mask_allowed || is_qdr) ? next_wm : {NLANE{1'b0}};
                wmask_oe_n_o <= !(mask_allowed || is_qdr);
            end else begin
                beat         <= 1'b0;
                // Stale parity or mask must not linger once the mode forbids it
                par_o        <= par_allowed ? par_o : {NPAR{1'b0}};
                wmask_o      <= (mask_allowed || is_qdr) ? wmask_o : {NLANE{1'b0}};
                dq_oe_n_o    <= 1'b1;
                wmask_oe_n_o <= 1'b1;
            end
        end
    end

    // Address and command at single rate; QDR write address in second half
    reg cmd_phase;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_phase  <= 1'b0;
            mem_addr_o <= {AW{1'b0}};
            mem_cmd_o  <= 4'h0;
        end else begin
            cmd_phase  <= ~cmd_phase;
            mem_cmd_o  <= cmd_i;
            mem_addr_o <= (is_qdr && cmd_phase) ? cmd_waddr_i : cmd_addr_i;
        end
    end

    // Memory clock pair from a toggle flop and a one-cycle-delayed copy of it
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_clk_o   <= 1'b0;
            mem_clk_n_o <= 1'b1;
            clk_fb_o    <= 1'b0;
        end else begin
            mem_clk_o   <= ~mem_clk_o;
            mem_clk_n_o <= mem_clk_o;
            clk_fb_o    <= diff_strobe_i ? (fbp_s2 & ~fbn_s2) : fbp_s2;
        end
    end

    // Read capture on strobe edges; read-valid handled as a data lane
    reg [DW-1:0] rd_lo;
    reg          rd_have_lo;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_lo        <= {DW{1'b0}};
            rd_have_lo   <= 1'b0;
            rd_data_o    <= {2*DW{1'b0}};
            rd_valid_o   <= 1'b0;
            rd_beat_hi_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            if (strobe_edge && rv_s2 && dll_locked_o) begin
                if (!half_rate_i) begin
                    rd_data_o  <= {{DW{1'b0}}, dq_s2};
                    rd_valid_o <= 1'b1;
                end else if (!rd_have_lo) begin
                    rd_lo      <= dq_s2;
                    rd_have_lo <= 1'b1;
                end else begin
                    rd_data_o    <= {dq_s2, rd_lo};
                    rd_valid_o   <= 1'b1;
                    rd_have_lo   <= 1'b0;
                    rd_beat_hi_o <= ~rd_beat_hi_o;
                end
            end else if (!rv_s2) begin
                rd_have_lo <= 1'b0;
            end
        end
    end

    // Shared delay loop plus side offset, applied to all strobes at once
    wire [5:0] dll_gray;
    wire       dll_lock;
    ddrpd_dll #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_dll (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .dll_reset_i (dlr_s2),
        .ref_edge_i  (ref_rise),
        .cmp_up_i    (cup_s2),
        .cmp_dn_i    (cdn_s2),
        .gray_o      (dll_gray),
        .locked_o    (dll_lock)
    );
    wire [5:0] shifted = dll_gray + side_offset_i;
    generate
        for (g = 0; g < NSTROBE; g = g + 1) begin : g_strobe
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    strobe_dly_o[6*g+5:6*g] <= `DDRPD_DLY_ZERO;
                end else if (strobe_edge) begin
                    strobe_dly_o[6*g+5:6*g] <= shifted;
                end
            end
        end
    endgenerate
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dll_locked_o <= 1'b0;
        end else begin
            dll_locked_o <= dll_lock;
        end
    end
endmodule // ddrpd_datapath

//--- logic/ddrpd_defs.vh
`ifndef DDRPD_DEFS_VH
`define DDRPD_DEFS_VH
`define DDRPD_CLK_PERIOD_NS 40
`define DDRPD_DLL_LOCK_CYCLES 1280
`define DDRPD_DLY_W 6
`define DDRPD_DLY_MAX 6'h3f
`define DDRPD_DLY_ZERO 6'h00
`define DDRPD_PAR_SPAN 8
`define DDRPD_BWS_SPAN 9
`define DDRPD_X4_LANES 4
`define DDRPD_MEM_DDR 2'h0
`define DDRPD_MEM_RLD 2'h1
`define DDRPD_MEM_QDR 2'h2
`define DDRPD_MEM_QDR8 2'h3
`define DDRPD_GRP_X4 2'h0
`define DDRPD_GRP_X8 2'h1
`define DDRPD_GRP_X16 2'h2
`define DDRPD_GRP_X32 2'h3
`define DDRPD_FIFO_DEPTH 8
`endif

//--- logic/ddrpd_dll.v
`include "ddrpd_defs.vh"
module ddrpd_dll #(
    parameter LOCK_CYCLES = `DDRPD_DLL_LOCK_CYCLES
) (
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    input  wire       dll_reset_i,
    input  wire       ref_edge_i,
    input  wire       cmp_up_i,
    input  wire       cmp_dn_i,
    output reg  [5:0] gray_o,
    output reg        locked_o
);
    reg [5:0]  bin;
    reg [10:0] lock_cnt;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bin      <= `DDRPD_DLY_ZERO;
            gray_o   <= `DDRPD_DLY_ZERO;
            lock_cnt <= 11'h000;
            locked_o <= 1'b0;
        end else if (dll_reset_i) begin
            bin      <= `DDRPD_DLY_ZERO;
            gray_o   <= `DDRPD_DLY_ZERO;
            lock_cnt <= 11'h000;
            locked_o <= 1'b0;
        end else if (ref_edge_i) begin
            if (cmp_up_i && !cmp_dn_i && bin != `DDRPD_DLY_MAX) begin
                bin    <= bin + 6'h01;
                gray_o <= (bin + 6'h01) ^ ((bin + 6'h01) >> 1);
            end else if (cmp_dn_i && !cmp_up_i && bin != `DDRPD_DLY_ZERO) begin
                bin    <= bin - 6'h01;
                gray_o <= (bin - 6'h01) ^ ((bin - 6'h01) >> 1);
            end
            // Lock waits a whole reference count, not a comparator match
            if (lock_cnt == LOCK_CYCLES[10:0] - 11'h001) begin
                locked_o <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 11'h001;
            end
        end
    end
endmodule // ddrpd_dll

//--- logic/ddrpd_fifo.v
module ddrpd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk_i,
    input  wire             reset_n_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = in_valid_i && in_ready_o;
    wire            pop  = out_valid_o && out_ready_i;
    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    always @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // ddrpd_fifo

//--- sim/ddrpd_datapath_chk.sv
`include "ddrpd_defs.vh"
module ddrpd_datapath_chk #(
    parameter DW      = 16,
    parameter NSTROBE = 4,
    parameter AW      = 14
) (
    input wire logic                 core_clk_i,
    input wire logic                 reset_n_i,
    input wire logic [1:0]           mem_type_i,
    input wire logic [1:0]           grp_mode_i,
    input wire logic                 diff_strobe_i,
    input wire logic                 is_ddr3_i,
    input wire logic                 parity_en_i,
    input wire logic                 wr_valid_i,
    input wire logic                 wr_ready_o,
    input wire logic [AW-1:0]        cmd_addr_i,
    input wire logic [3:0]           cmd_i,
    input wire logic [AW-1:0]        mem_addr_o,
    input wire logic [3:0]           mem_cmd_o,
    input wire logic [DW-1:0]        dq_o,
    input wire logic                 dq_oe_n_o,
    input wire logic [DW/8-1:0]      par_o,
    input wire logic [DW/4-1:0]      wmask_o,
    input wire logic                 wmask_oe_n_o,
    input wire logic                 rd_valid_o,
    input wire logic                 mem_clk_o,
    input wire logic                 mem_clk_n_o,
    input wire logic [6*NSTROBE-1:0] strobe_dly_o,
    input wire logic                 dll_locked_o
);
    logic [1:0] up_cnt;
    wire        mask_off = mem_type_i == `DDRPD_MEM_DDR && grp_mode_i == `DDRPD_GRP_X4 && (is_ddr3_i || diff_strobe_i);
    wire        ddr_wide = mem_type_i == `DDRPD_MEM_DDR && grp_mode_i != `DDRPD_GRP_X4;
    function automatic logic [DW/8-1:0] even_par(input logic [DW-1:0] d);
        for (int i = 0; i < DW/8; i++) even_par[i] = ^d[8*i +: 8];
    endfunction
    // Skips the first cycles after reset, where $past still returns values sampled during reset
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_wr_take;
        wr_valid_i && wr_ready_o && dq_oe_n_o;
    endsequence
    sequence s_beat_out;
        ##[1:2] !dq_oe_n_o;
    endsequence
    sequence s_pulse;
        rd_valid_o ##1 !rd_valid_o;
    endsequence
    chk_write_launch: assert property (s_wr_take |-> s_beat_out)
        else $error("write word not launched");
    chk_parity_even: assert property (!dq_oe_n_o && parity_en_i && grp_mode_i != `DDRPD_GRP_X4
        |-> par_o == even_par(dq_o))
        else $error("parity not even over its byte");
    chk_parity_off: assert property ((grp_mode_i == `DDRPD_GRP_X4 || !parity_en_i) [*2] |-> par_o == '0)
        else $error("parity driven where not offered");
    chk_mask_x4_off: assert property (mask_off [*2] |-> wmask_o == '0 && wmask_oe_n_o)
        else $error("mask driven in x4 mode");
    chk_mask_with_dq: assert property (ddr_wide [*2] |-> wmask_oe_n_o == dq_oe_n_o)
        else $error("mask enable differs from data enable");
    chk_clk_pair: assert property (up_cnt == 2'h3
        |-> mem_clk_n_o == !mem_clk_o && mem_clk_o != $past(mem_clk_o))
        else $error("memory clock pair wrong");
    chk_dly_same: assert property (strobe_dly_o == {NSTROBE{strobe_dly_o[5:0]}})
        else $error("strobe delay slices differ");
    chk_rd_pulse: assert property (rd_valid_o |-> s_pulse)
        else $error("read valid longer than a cycle");
    chk_rd_locked: assert property (rd_valid_o |-> $past(dll_locked_o))
        else $error("read word delivered before lock");
    chk_addr_sdr: assert property (up_cnt == 2'h3 && mem_type_i == `DDRPD_MEM_DDR
        |=> mem_addr_o == $past(cmd_addr_i) && mem_cmd_o == $past(cmd_i))
        else $error("address or command not one cycle later");
endmodule // ddrpd_datapath_chk
bind ddrpd_datapath ddrpd_datapath_chk #(.DW(DW), .NSTROBE(NSTROBE), .AW(AW)) u_chk (
    .core_clk_i, .reset_n_i, .mem_type_i, .grp_mode_i, .diff_strobe_i, .is_ddr3_i, .parity_en_i,
    .wr_valid_i, .wr_ready_o, .cmd_addr_i, .cmd_i, .mem_addr_o, .mem_cmd_o, .dq_o, .dq_oe_n_o, .par_o,
    .wmask_o, .wmask_oe_n_o, .rd_valid_o, .mem_clk_o, .mem_clk_n_o, .strobe_dly_o, .dll_locked_o);

//--- sim/ddrpd_mem_model.sv
module ddrpd_mem_model #(
    parameter DW = 16
) (
    input  wire logic          mem_clk_i,
    input  wire logic          mem_clk_n_i,
    output logic [DW-1:0]      dq_o,
    output logic               rvalid_o,
    output logic               strobe_o,
    output wire logic          fb_p_o,
    output wire logic          fb_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock pair comes straight back on the feedback inputs
    assign fb_p_o = mem_clk_i;
    assign fb_n_o = mem_clk_n_i;
    initial begin
        dq_o = '0;
        rvalid_o = 1'b0;
        strobe_o = 1'b0;
    end
    // Beats edge-aligned with strobe toggles, valid leads by half a period
    // Strobe stands still between frames; training frames keep valid low
    task automatic frame(input int n, input logic [DW-1:0] base, input logic vld);
        #67;
        rvalid_o = vld;
        #160;
        for (int i = 0; i < n; i++) begin
            dq_o = base + DW'(i);
            strobe_o = ~strobe_o;
            #160;
        end
        rvalid_o = 1'b0;
        // Released bus must not look like a held word
        dq_o = ~dq_o;
    endtask
endmodule // ddrpd_mem_model

//--- sim/tb_ddrpd_datapath.sv
`include "ddrpd_defs.vh"
module tb_ddrpd_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 1'b0, reset_n_i = 1'b0, diff_strobe_i = 1'b0, is_ddr3_i = 1'b0, half_rate_i = 1'b1;
    logic        parity_en_i = 1'b1, ecc_en_i = 1'b0, wr_valid_i = 1'b0, dll_reset_i = 1'b0;
    logic        cmp_up_i = 1'b0, cmp_dn_i = 1'b0;
    logic [1:0]  mem_type_i = 2'h0, grp_mode_i = 2'h1;
    logic [31:0] wr_data_i = '0;
    logic [3:0]  wr_mask_i = 4'h0, cmd_i = 4'h0;
    logic [13:0] cmd_addr_i = '0, cmd_waddr_i = '0;
    logic [5:0]  side_offset_i = 6'h00;
    wire         wr_ready_o, dq_oe_n_o, wmask_oe_n_o, rd_valid_o, rd_beat_hi_o, mem_clk_o, mem_clk_n_o, clk_fb_o;
    wire         dll_locked_o, rvalid_pin_i, strobe_pin_i, mem_clk_fb_p_i, mem_clk_fb_n_i;
    wire [13:0]  mem_addr_o;
    wire [3:0]   mem_cmd_o, wmask_o;
    wire [15:0]  dq_o, dq_i;
    wire [1:0]   par_o;
    wire [31:0]  rd_data_o;
    wire [23:0]  strobe_dly_o;
    int          err_count = 0, num_checks = 0;
    logic [15:0] wq[$];
    logic [4:0]  mq[$];
    logic [31:0] rq[$];
    always #20 core_clk_i = ~core_clk_i;
    // Short lock count keeps the run brief
    ddrpd_datapath #(.DW(16), .NSTROBE(4), .LOCK_CYCLES(8), .FIFO_DEPTH(8), .AW(14)) dut (
        .core_clk_i, .reset_n_i, .mem_type_i, .grp_mode_i, .diff_strobe_i, .is_ddr3_i, .half_rate_i, .parity_en_i,
        .ecc_en_i, .wr_data_i, .wr_mask_i, .wr_valid_i, .wr_ready_o, .cmd_addr_i, .cmd_waddr_i, .cmd_i, .mem_addr_o,
        .mem_cmd_o, .dq_o, .dq_oe_n_o, .par_o, .wmask_o, .wmask_oe_n_o, .dq_i, .rvalid_pin_i, .strobe_pin_i,
        .rd_data_o, .rd_valid_o, .rd_beat_hi_o, .mem_clk_o, .mem_clk_n_o, .mem_clk_fb_p_i, .mem_clk_fb_n_i,
        .clk_fb_o, .dll_reset_i, .cmp_up_i, .cmp_dn_i, .side_offset_i, .strobe_dly_o, .dll_locked_o);
    ddrpd_mem_model #(.DW(16)) mem (.mem_clk_i(mem_clk_o), .mem_clk_n_i(mem_clk_n_o), .dq_o(dq_i),
        .rvalid_o(rvalid_pin_i), .strobe_o(strobe_pin_i), .fb_p_o(mem_clk_fb_p_i), .fb_n_o(mem_clk_fb_n_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        if (dq_oe_n_o === 1'b0) begin
            wq.push_back(dq_o);
            mq.push_back({wmask_oe_n_o, wmask_o});
            check(par_o, (parity_en_i && grp_mode_i != 2'h0) ? {^dq_o[15:8], ^dq_o[7:0]} : 2'h0);
        end
        if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    end
    task automatic wr_words(input int n, input logic [3:0] mask, output int stalls);
        int i = 0;
        stalls = 0;
        wq.delete();
        mq.delete();
        while (i < n) begin
            @(negedge core_clk_i);
            wr_valid_i = 1'b1;
            wr_data_i = {16'hb000 + 16'(2*i+1), 16'hb000 + 16'(2*i)};
            wr_mask_i = mask;
            @(posedge core_clk_i);
            if (wr_ready_o === 1'b1) i++;
            else stalls++;
        end
        @(negedge core_clk_i);
        wr_valid_i = 1'b0;
        for (int t = 0; t < 80 && dq_oe_n_o !== 1'b1; t++) @(negedge core_clk_i);
        check(wq.size(), 2*n);
        for (int k = 0; k < wq.size(); k++) check(wq[k], 16'hb000 + 16'(k));
    endtask
    task automatic sc_lock();
        rq.delete();
        mem.frame(4, 16'h0100, 1'b1);
        repeat (8) @(negedge core_clk_i);
        check(rq.size(), 0);
        check(dll_locked_o, 1'b0);
        mem.frame(14, 16'h0000, 1'b0);
        repeat (8) @(negedge core_clk_i);
        check(dll_locked_o, 1'b1);
        dll_reset_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        check(dll_locked_o, 1'b0);
        dll_reset_i = 1'b0;
        mem.frame(18, 16'h0000, 1'b0);
        repeat (8) @(negedge core_clk_i);
        check(dll_locked_o, 1'b1);
    endtask
    task automatic sc_read();
        rq.delete();
        mem.frame(6, 16'h1111, 1'b1);
        repeat (8) @(negedge core_clk_i);
        check(rq.size(), 3);
        check(rd_beat_hi_o, 1'b1);
        check(rq[0], 32'h1112_1111);
        check(rq[1], 32'h1114_1113);
        half_rate_i = 1'b0;
        rq.delete();
        mem.frame(2, 16'h5a50, 1'b1);
        repeat (8) @(negedge core_clk_i);
        check(rq.size(), 2);
        check(rq[1][15:0], 16'h5a51);
        half_rate_i = 1'b1;
    endtask
    task automatic sc_fill();
        int st;
        wr_words(20, 4'h0, st);
        check(st != 0, 1'b1);
        check(mq[0], 5'h00);
    endtask
    task automatic sc_mask();
        logic [1:0] tp[6] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
        logic [1:0] gm[6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
        logic [3:0] mk[6] = '{4'h2, 4'hf, 4'h1, 4'he, 4'h5, 4'hf};
        logic [4:0] ex[6] = '{5'h0c, 5'h10, 5'h0f, 5'h00, 5'h05, 5'h10};
        int st;
        for (int r = 0; r < 6; r++) begin
            @(negedge core_clk_i);
            mem_type_i = tp[r];
            grp_mode_i = gm[r];
            is_ddr3_i = (r == 1);
            diff_strobe_i = (r == 5);
            parity_en_i = (r != 2);
            wr_words(2, mk[r], st);
            foreach (mq[k]) check(mq[k], ex[r]);
        end
        mem_type_i = 2'h0;
        grp_mode_i = 2'h1;
        is_ddr3_i = 1'b0;
        diff_strobe_i = 1'b0;
        parity_en_i = 1'b1;
    endtask
    task automatic sc_dll();
        logic [5:0] prev;
        int steps = 0;
        prev = strobe_dly_o[5:0];
        cmp_up_i = 1'b1;
        fork
            mem.frame(16, 16'h0000, 1'b0);
            repeat (100) begin
                @(negedge core_clk_i);
                check(strobe_dly_o, {4{strobe_dly_o[5:0]}});
                if (strobe_dly_o[5:0] !== prev) begin
                    check($countones(strobe_dly_o[5:0] ^ prev), 1);
                    steps++;
                end
                prev = strobe_dly_o[5:0];
            end
        join
        cmp_up_i = 1'b0;
        check(steps, 8);
        check(prev, 6'h0c);
        // Settings only move on strobe edges, so the offset needs a frame
        cmp_dn_i = 1'b1;
        side_offset_i = 6'h05;
        mem.frame(2, 16'h0000, 1'b0);
        repeat (6) @(negedge core_clk_i);
        check(strobe_dly_o, {4{6'h09}});
        cmp_dn_i = 1'b0;
        side_offset_i = 6'h00;
    endtask
    task automatic sc_addr();
        logic fb;
        logic [13:0] a0;
        cmd_addr_i = 14'h1a5c;
        cmd_waddr_i = 14'h0333;
        cmd_i = 4'h6;
        @(negedge core_clk_i);
        check(mem_addr_o, 14'h1a5c);
        check(mem_cmd_o, 4'h6);
        fb = clk_fb_o;
        @(negedge core_clk_i);
        check(clk_fb_o, !fb);
        check(mem_clk_n_o, !mem_clk_o);
        mem_type_i = 2'h2;
        @(negedge core_clk_i);
        a0 = mem_addr_o;
        @(negedge core_clk_i);
        check(a0 ^ mem_addr_o, 14'h1a5c ^ 14'h0333);
        mem_type_i = 2'h0;
    endtask
    initial begin
        #100_000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge core_clk_i);
        check(dq_oe_n_o, 1'b1);
        check({mem_clk_o, mem_clk_n_o}, 2'b01);
        reset_n_i = 1'b1;
        sc_lock();
        sc_read();
        sc_fill();
        sc_mask();
        sc_dll();
        sc_addr();
        conclude();
    end
endmodule // tb_ddrpd_datapath
